// [src/pbm_regs.sv]
// Purpose: Basic control and status registers of a 10/100 transceiver
// Assumes: Management access decoded into index/strobe ports on clk
// Notes:   Other mapped indices are served by the ext_* pass-through port
//
// Functional notes
// - Only indices 0-6,17,18,26,27,29-31 exist
// - Control bit 15 soft reset, self-clearing
// - Soft reset keeps speed, autoneg, duplex; clears loopback, power-down, isolate, collision test
// - Speed, autoneg, duplex defaults from mode strap
// - Bit 13 selects 100/10, ignored under autoneg
// - Bit 8 selects full/half, ignored under autoneg
// - Bit 12 enables autoneg, overrides forced bits
// - Bit 10 isolates from MAC data interface
// - Bit 9 restarts autoneg, self-clearing
// - Bit 7 enables collision test, reset zero
// - Status 14..11 one; 15,10,9 zero
// - Status bit 8 reads zero
// - Status bit 5 shows autoneg complete
// - Status bit 4 latched-high remote fault
// - Status bit 3 reads constant one
// - Status bit 1 latched-high jabber
// - Status bit 0 reads constant one
// - Latched-high held until status read
// - Latched-low released by status read
`timescale 1ns/100ps
module pbm_regs
    import pbm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [2:0]  mode_strap,
    input  wire logic [4:0]  reg_index,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    input  wire logic [15:0] ext_rdata,
    input  wire logic        an_complete,
    input  wire logic        remote_fault,
    input  wire logic        jabber,
    input  wire logic        link_up,
    output logic [15:0]      reg_rdata,
    output logic             reg_rvalid,
    output logic             ext_sel,
    output logic             soft_reset,
    output logic             loopback,
    output logic             speed_100,
    output logic             full_duplex,
    output logic             an_enable,
    output logic             an_restart,
    output logic             power_down,
    output logic             isolate,
    output logic             col_test
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0]  mode_s1;
        logic [2:0]  mode_s2;
        logic        strap_done;
        logic [1:0]  strap_cnt;
        logic [3:0]  ev_s1;
        logic [3:0]  ev_s2;
        logic        srst;
        logic [2:0]  srst_cnt;
        logic        loopback;
        logic        speed;
        logic        an_en;
        logic        pdown;
        logic        isolate;
        logic        an_rst;
        logic        duplex;
        logic        coltest;
        logic        rfault;
        logic        jabber;
        logic        link;
        logic [15:0] rdata;
        logic        rvalid;
        logic        ext_sel;
        logic        speed_eff;
        logic        duplex_eff;
    } pbm_state_t;

    pbm_state_t s_q;
    pbm_state_t s_d;

    logic        idx_ok;
    logic [15:0] status_word;
    logic [15:0] ctrl_word;
    logic        an_done_s;
    logic        rf_s;
    logic        jab_s;
    logic        link_s;

    // ****************************************
    // Decode and read words
    // ****************************************
    always_comb begin
        unique case (reg_index)
            PBM_IDX_CONTROL, PBM_IDX_STATUS, PBM_IDX_ID_HI, PBM_IDX_ID_LO,
            PBM_IDX_ADV, PBM_IDX_PARTNER, PBM_IDX_EXPAN, PBM_IDX_MODE_CS,
            PBM_IDX_SPECIAL, PBM_IDX_SYMERR, PBM_IDX_CSIND, PBM_IDX_IRQ_SRC,
            PBM_IDX_IRQ_MSK, PBM_IDX_SPC_CS: idx_ok = 1'b1;
            default:                         idx_ok = 1'b0;
        endcase
    end

    assign an_done_s = s_q.ev_s2[0];
    assign rf_s      = s_q.ev_s2[1];
    assign jab_s     = s_q.ev_s2[2];
    assign link_s    = s_q.ev_s2[3];

    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[PBM_CTL_RESET]    = s_q.srst;
        ctrl_word[PBM_CTL_LOOPBACK] = s_q.loopback;
        ctrl_word[PBM_CTL_SPEED]    = s_q.speed;
        ctrl_word[PBM_CTL_AN_EN]    = s_q.an_en;
        ctrl_word[PBM_CTL_PDOWN]    = s_q.pdown;
        ctrl_word[PBM_CTL_ISOLATE]  = s_q.isolate;
        ctrl_word[PBM_CTL_AN_RST]   = s_q.an_rst;
        ctrl_word[PBM_CTL_DUPLEX]   = s_q.duplex;
        ctrl_word[PBM_CTL_COLTEST]  = s_q.coltest;
    end

    always_comb begin
        status_word = PBM_ST_FIXED;
        status_word[PBM_ST_AN_DONE] = an_done_s;
        status_word[PBM_ST_RFAULT]  = s_q.rfault;
        status_word[PBM_ST_LINK]    = s_q.link;
        status_word[PBM_ST_JABBER]  = s_q.jabber;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.mode_s1 = mode_strap;
        s_d.mode_s2 = s_q.mode_s1;
        s_d.ev_s1   = {link_up, jabber, remote_fault, an_complete};
        s_d.ev_s2   = s_q.ev_s1;
        s_d.rvalid  = 1'b0;
        s_d.ext_sel = 1'b0;

        // Strap taken once, after both sync stages have filled
        if (!s_q.strap_done) begin
            if (s_q.strap_cnt == 2'h2) begin
                s_d.strap_done = 1'b1;
                s_d.speed  = s_q.mode_s2[PBM_MODE_SPEED];
                s_d.duplex = s_q.mode_s2[PBM_MODE_DUPLEX];
                s_d.an_en  = s_q.mode_s2[PBM_MODE_AN];
            end else begin
                s_d.strap_cnt = s_q.strap_cnt + 2'h1;
            end
        end

        // Self-clearing restart pulse
        s_d.an_rst = 1'b0;

        // Soft reset: clears ordinary bits, keeps mode bits from registers
        if (s_q.srst) begin
            if (s_q.srst_cnt == 3'(PBM_SRST_CYCLES - 1)) begin
                s_d.srst     = 1'b0;
                s_d.srst_cnt = 3'h0;
            end else begin
                s_d.srst_cnt = s_q.srst_cnt + 3'h1;
            end
            s_d.loopback = 1'b0;
            s_d.pdown    = 1'b0;
            s_d.isolate  = 1'b0;
            s_d.coltest  = 1'b0;
        end

        // Latched status: event set wins over read clear
        if (reg_rd && reg_index == PBM_IDX_STATUS) begin
            s_d.rfault = rf_s;
            s_d.jabber = jab_s;
            s_d.link   = link_s;
        end else begin
            s_d.rfault = s_q.rfault | rf_s;
            s_d.jabber = s_q.jabber | jab_s;
            s_d.link   = s_q.link & link_s;
        end

        if (reg_wr && reg_index == PBM_IDX_CONTROL && !s_q.srst) begin
            if (reg_wdata[PBM_CTL_RESET]) begin
                // Other bits of this write are not applied
                s_d.srst     = 1'b1;
                s_d.srst_cnt = 3'h0;
            end else begin
                s_d.loopback = reg_wdata[PBM_CTL_LOOPBACK];
                s_d.speed    = reg_wdata[PBM_CTL_SPEED];
                s_d.an_en    = reg_wdata[PBM_CTL_AN_EN];
                s_d.pdown    = reg_wdata[PBM_CTL_PDOWN];
                s_d.isolate  = reg_wdata[PBM_CTL_ISOLATE];
                s_d.an_rst   = reg_wdata[PBM_CTL_AN_RST];
                s_d.duplex   = reg_wdata[PBM_CTL_DUPLEX];
                s_d.coltest  = reg_wdata[PBM_CTL_COLTEST];
            end
        end

        // Forced speed/duplex only count with autoneg off
        s_d.speed_eff  = s_d.an_en ? 1'b1 : s_d.speed;
        s_d.duplex_eff = s_d.an_en ? 1'b1 : s_d.duplex;

        if (reg_rd) begin
            s_d.rvalid = 1'b1;
            if (reg_index == PBM_IDX_CONTROL) begin
                s_d.rdata = ctrl_word;
            end else if (reg_index == PBM_IDX_STATUS) begin
                s_d.rdata = status_word;
            end else if (idx_ok) begin
                s_d.rdata = ext_rdata;
            end else begin
                s_d.rdata = PBM_RD_NONE;
            end
        end
        if ((reg_rd || reg_wr) && idx_ok && reg_index != PBM_IDX_CONTROL && reg_index != PBM_IDX_STATUS) begin
            s_d.ext_sel = 1'b1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign reg_rdata   = s_q.rdata;
    assign reg_rvalid  = s_q.rvalid;
    assign ext_sel     = s_q.ext_sel;
    assign soft_reset  = s_q.srst;
    assign loopback    = s_q.loopback;
    assign speed_100   = s_q.speed_eff;
    assign full_duplex = s_q.duplex_eff;
    assign an_enable   = s_q.an_en;
    assign an_restart  = s_q.an_rst;
    assign power_down  = s_q.pdown;
    assign isolate     = s_q.isolate;
    assign col_test    = s_q.coltest;

endmodule : pbm_regs

// [src/pbm_pkg.sv]
// Purpose: Constants for the management register bank
// Assumes: 5-bit register index, 16-bit registers
// Notes:   Bit positions follow the control/status layout
package pbm_pkg;
    localparam logic [4:0] PBM_IDX_CONTROL = 5'h00;
    localparam logic [4:0] PBM_IDX_STATUS  = 5'h01;
    localparam logic [4:0] PBM_IDX_ID_HI   = 5'h02;
    localparam logic [4:0] PBM_IDX_ID_LO   = 5'h03;
    localparam logic [4:0] PBM_IDX_ADV     = 5'h04;
    localparam logic [4:0] PBM_IDX_PARTNER = 5'h05;
    localparam logic [4:0] PBM_IDX_EXPAN   = 5'h06;
    localparam logic [4:0] PBM_IDX_MODE_CS = 5'h11;
    localparam logic [4:0] PBM_IDX_SPECIAL = 5'h12;
    localparam logic [4:0] PBM_IDX_SYMERR  = 5'h1A;
    localparam logic [4:0] PBM_IDX_CSIND   = 5'h1B;
    localparam logic [4:0] PBM_IDX_IRQ_SRC = 5'h1D;
    localparam logic [4:0] PBM_IDX_IRQ_MSK = 5'h1E;
    localparam logic [4:0] PBM_IDX_SPC_CS  = 5'h1F;
    localparam int PBM_CTL_RESET    = 15;
    localparam int PBM_CTL_LOOPBACK = 14;
    localparam int PBM_CTL_SPEED    = 13;
    localparam int PBM_CTL_AN_EN    = 12;
    localparam int PBM_CTL_PDOWN    = 11;
    localparam int PBM_CTL_ISOLATE  = 10;
    localparam int PBM_CTL_AN_RST   = 9;
    localparam int PBM_CTL_COLTEST  = 8 - 1;
    localparam int PBM_CTL_DUPLEX   = 8;
    localparam int PBM_ST_AN_DONE   = 5;
    localparam int PBM_ST_RFAULT    = 4;
    localparam int PBM_ST_LINK      = 2;
    localparam int PBM_ST_JABBER    = 1;
    // Fixed status: abilities 14..11, AN able (3), extended caps (0)
    localparam logic [15:0] PBM_ST_FIXED = 16'h7809;
    // Strap mode: bit2 speed, bit1 duplex, bit0 autoneg
    localparam int PBM_MODE_SPEED  = 2;
    localparam int PBM_MODE_DUPLEX = 1;
    localparam int PBM_MODE_AN     = 0;
    localparam int PBM_SRST_CYCLES = 4;
    localparam logic [15:0] PBM_RD_NONE = 16'h0000;
endpackage : pbm_pkg

// [sim/pbm_regs_asserts.sv]
// Purpose: Port assertions for the register bank
// Assumes: Clock enable held high by the bench
// Notes:   Bound into every pbm_regs instance
`timescale 1ns/100ps
module pbm_regs_asserts
    import pbm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [4:0]  reg_index,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        ext_sel,
    input wire logic        soft_reset,
    input wire logic        loopback,
    input wire logic        speed_100,
    input wire logic        full_duplex,
    input wire logic        an_enable,
    input wire logic        an_restart,
    input wire logic        power_down,
    input wire logic        isolate,
    input wire logic        col_test
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire cw = reg_wr && reg_index == PBM_IDX_CONTROL && !soft_reset && !reg_wdata[15];
    wire sw = reg_wr && reg_index == PBM_IDX_CONTROL && !soft_reset && reg_wdata[15];
    wire ext = reg_index inside {[5'h02:5'h06], 5'h11, 5'h12, 5'h1A, 5'h1B, [5'h1D:5'h1F]};
    srst_len_a: assert property (sw |=> soft_reset[*4] ##1 !soft_reset) else $error("soft reset length");
    srst_keep_a: assert property (sw |=> ($stable(an_enable) && $stable(speed_100)
        && $stable(full_duplex)) ##1 (!loopback && !power_down && !isolate && !col_test))
        else $error("soft reset effect wrong");
    ctl_bits_a: assert property (cw |=> loopback == $past(reg_wdata[PBM_CTL_LOOPBACK])
        && isolate == $past(reg_wdata[PBM_CTL_ISOLATE]) && power_down == $past(reg_wdata[PBM_CTL_PDOWN])
        && col_test == $past(reg_wdata[PBM_CTL_COLTEST])) else $error("control bit");
    forced_a: assert property (cw && !reg_wdata[PBM_CTL_AN_EN] |=> !an_enable
        && speed_100 == $past(reg_wdata[PBM_CTL_SPEED])
        && full_duplex == $past(reg_wdata[PBM_CTL_DUPLEX])) else $error("forced mode");
    an_over_a: assert property (an_enable |-> speed_100 && full_duplex) else $error("autoneg override");
    an_pulse_a: assert property (cw && reg_wdata[PBM_CTL_AN_RST] |=> an_restart ##1 !an_restart)
        else $error("restart");
    st_fixed_a: assert property (reg_rd && reg_index == PBM_IDX_STATUS
        |=> (reg_rdata & 16'hFF09) == PBM_ST_FIXED) else $error("status fixed bits");
    map_sel_a: assert property ((reg_rd || reg_wr) && reg_index > 5'h01 |=> ext_sel == $past(ext))
        else $error("index select");
    map_none_a: assert property (reg_rd && !ext && reg_index > 5'h01 |=> reg_rdata == PBM_RD_NONE)
        else $error("unmapped read");
endmodule : pbm_regs_asserts
bind pbm_regs pbm_regs_asserts pbm_regs_asserts_i (
    .clk         (clk),
    .rst         (rst),
    .reg_index   (reg_index),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_wdata   (reg_wdata),
    .reg_rdata   (reg_rdata),
    .ext_sel     (ext_sel),
    .soft_reset  (soft_reset),
    .loopback    (loopback),
    .speed_100   (speed_100),
    .full_duplex (full_duplex),
    .an_enable   (an_enable),
    .an_restart  (an_restart),
    .power_down  (power_down),
    .isolate     (isolate),
    .col_test    (col_test)
);

// [sim/pbm_smc_model.sv]
// Purpose: Management controller model making register accesses
// Assumes: One access at a time
// Notes:   Cleans control writes as the far side must
`timescale 1ns/100ps
module pbm_smc_model
    import pbm_pkg::*;
(
    input  wire logic   clk,
    output logic [4:0]  reg_index,
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_index = 5'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
        if (a == PBM_IDX_CONTROL && d[PBM_CTL_RESET]) d = 16'h8000;
        if (a == PBM_IDX_CONTROL && d[PBM_CTL_PDOWN]) d[PBM_CTL_AN_EN] = 1'b0;
        @(posedge clk);
        reg_index <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : access
endmodule : pbm_smc_model

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the register bank
// Assumes: Strap 3'h5, then 3'h2 after a mid-run reset, clock enable high
// Notes:   Read words checked from a queue at negedge
`timescale 1ns/100ps
module tb_top
    import pbm_pkg::*;
();
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] ext_d = 16'h0000;
    logic [2:0]  strap = 3'h5;
    logic [3:0]  cond = 4'h0;
    logic [4:0]  idx;
    logic        wr, rd, rv, srst, lb, spd, fd, ane, pd, iso, ct;
    logic [15:0] wd, rdat;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'hB425;
    int          fails = 0;
    int          n_checks = 0;
    logic [39:0] ctl_t[5] = '{{16'h0000, 16'h3000, 8'h38}, {16'h4180, 16'h4180, 8'h51},
        {16'h8000, 16'h0100, 8'h10}, {16'h0C00, 16'h0C00, 8'h06}, {16'h1200, 16'h1000, 8'h38}};
    logic [19:0] st_t[7] = '{{4'h0, 16'h7809}, {4'hF, 16'h783B}, {4'h9, 16'h783F}, {4'h9, 16'h782D},
        {4'h8, 16'h7829}, {4'h9, 16'h7829}, {4'h9, 16'h782D}};
    always #20 clk = ~clk;
    pbm_smc_model pbm_smc_model_i (.clk(clk), .reg_index(idx), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd));
    pbm_regs pbm_regs_i (.clk(clk), .rst(rst), .ce(1'b1), .mode_strap(strap), .reg_index(idx), .reg_wr(wr),
        .reg_rd(rd), .reg_wdata(wd), .ext_rdata(ext_d), .an_complete(cond[3]), .remote_fault(cond[2]),
        .jabber(cond[1]), .link_up(cond[0]), .reg_rdata(rdat), .reg_rvalid(rv), .ext_sel(),
        .soft_reset(srst), .loopback(lb), .speed_100(spd), .full_duplex(fd), .an_enable(ane),
        .an_restart(), .power_down(pd), .isolate(iso), .col_test(ct));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        pbm_smc_model_i.access(a, 1'b0, 16'h0000);
    endtask : rd_reg
    task automatic give_verdict();
        fails += exp_q.size();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    always @(negedge clk) begin
        if (rv === 1'b1) begin
            chk("read data", exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX, rdat);
        end
    end
    initial begin
        int i;
        int k;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        for (i = 0; i < 5; i++) begin
            if (i > 0) pbm_smc_model_i.access(PBM_IDX_CONTROL, 1'b1, ctl_t[i][39:24]);
            if (i == 2) begin
                // Write during soft reset must be dropped
                pbm_smc_model_i.access(PBM_IDX_CONTROL, 1'b1, 16'h4000);
                for (k = 0; k < 20 && srst !== 1'b0; k++) @(negedge clk);
                if (srst !== 1'b0) begin
                    fails++;
                    give_verdict();
                end
            end
            rd_reg(PBM_IDX_CONTROL, ctl_t[i][23:8]);
            #1;
            chk("flags", {8'h00, ctl_t[i][7:0]}, {8'h00, srst, lb, spd, fd, ane, pd, iso, ct});
        end
        $display("test control done");
        @(posedge clk);
        for (i = 0; i < 7; i++) begin
            cond <= st_t[i][19:16];
            repeat (6) @(posedge clk);
            rd_reg(PBM_IDX_STATUS, st_t[i][15:0]);
        end
        $display("test status done");
        for (i = 2; i < 32; i++) begin
            seed = xs(seed);
            ext_d <= seed[15:0];
            rd_reg(5'(i), (i <= 6 || i inside {17, 18, 26, 27, 29, 30, 31}) ? seed[15:0] : PBM_RD_NONE);
        end
        repeat (4) @(posedge clk);
        $display("test index map done");
        // Mid-run reset with a new strap: defaults must follow it
        strap <= 3'h2;
        rst   <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd_reg(PBM_IDX_CONTROL, 16'h0100);
        #1;
        chk("flags", 16'h0010, {8'h00, srst, lb, spd, fd, ane, pd, iso, ct});
        repeat (4) @(posedge clk);
        $display("test strap reset done");
        give_verdict();
    end
endmodule : tb_top
